//--- bench/lccc_cell_model.sv
`timescale 1ns/1ps
////////////////////////////////
module lccc_cell_model (
    input  wire logic supply_on,
    input  wire logic signed [31:0] cell_mv,
    input  wire logic charge_enable,
    output logic      supply_rise_ok,
    output logic      supply_fall_ok,
    output logic      headroom_70_ok,
    output logic      headroom_35_ok,
    output logic      cell_terminal_above_trickle,
    output logic      cell_terminal_below_recharge,
    output logic      charge_current_tenth
);
    // Supply sits at 5 V when present
    assign supply_rise_ok = supply_on;
    assign supply_fall_ok = supply_on;
    assign headroom_70_ok = supply_on && cell_mv < 4930;
    assign headroom_35_ok = supply_on && cell_mv < 4965;
    assign cell_terminal_above_trickle = cell_mv > 2480;
    assign cell_terminal_below_recharge = cell_mv < 4050;
    // Taper only while current flows
    assign charge_current_tenth = charge_enable && cell_mv >= 4150;
endmodule : lccc_cell_model

//--- bench/testbench.sv
`timescale 1ns/1ps
////////////////////////////////
module testbench;
    logic        clock, resetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        supply_rise_ok, supply_fall_ok, headroom_70_ok;
    logic        headroom_35_ok, current_set_pin_ok, power_down_n;
    logic        cell_terminal_above_trickle, cell_terminal_below_recharge;
    logic        charge_current_tenth, die_temp_limit, pack_thermistor_in_bad;
    logic        pack_thermistor_in_grounded, timer_pin_grounded, supply_on;
    logic        charge_enable, current_scale_tenth, current_reduce;
    logic        charge_status_out_o, charge_status_out_oe_n, fault_out_o;
    logic        charge_status_weak_en, fault_out_oe_n, supply_present_out_o;
    logic        supply_present_out_oe_n;
    int          fail_count, compares, cell_mv;
    assign hready = hreadyout;
    lccc_charge_ctrl #(.TICK_CYCLES(2)) i_lccc_charge_ctrl (
        .clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .supply_rise_ok,
        .supply_fall_ok, .headroom_70_ok, .headroom_35_ok,
        .current_set_pin_ok, .power_down_n, .cell_terminal_above_trickle,
        .cell_terminal_below_recharge, .charge_current_tenth,
        .die_temp_limit, .pack_thermistor_in_bad,
        .pack_thermistor_in_grounded, .timer_pin_grounded, .charge_enable,
        .current_scale_tenth, .current_reduce, .charge_status_out_o,
        .charge_status_out_oe_n, .charge_status_weak_en, .fault_out_o,
        .fault_out_oe_n, .supply_present_out_o, .supply_present_out_oe_n
    );
    lccc_cell_model i_lccc_cell_model (
        .supply_on, .cell_mv, .charge_enable, .supply_rise_ok,
        .supply_fall_ok, .headroom_70_ok, .headroom_35_ok,
        .cell_terminal_above_trickle, .cell_terminal_below_recharge,
        .charge_current_tenth
    );
    ////////////////////////////////
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // Master holds each phase until hready is seen high
    task automatic bus(input logic wr, input logic [11:0] a, input int d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {20'h0, a};
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic st(input lccc_pkg::lccc_state_t s);
        bus(1'b0, lccc_pkg::OFF_STATUS, 0);
        chk("state", {29'h0, s}, {29'h0, rd[2:0]});
    endtask : st
    ////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (70000) @(posedge clock);
        fail_count++;
        summarize();
    end
    initial begin
        {resetn, hsel, haddr, htrans, hwrite, hwdata, supply_on} = '0;
        {die_temp_limit, pack_thermistor_in_bad, fail_count, compares} = '0;
        {pack_thermistor_in_grounded, timer_pin_grounded} = '0;
        {hsize, current_set_pin_ok, power_down_n} = {3'h2, 2'h3};
        cell_mv = 3700;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        bus(1'b0, lccc_pkg::OFF_CTRL, 0);
        chk("ctrl", 32'h64, rd);
        st(lccc_pkg::ST_SLEEP);
        bus(1'b0, 12'h0f0, 0);
        chk("unmapped", 32'h0, rd);
        chk("present", 1, supply_present_out_oe_n);
        chk("fixed", 32'h10, {hreadyout, hresp, charge_status_out_o,
            fault_out_o, supply_present_out_o});
        $display("test reset done");
        supply_on <= 1'b1;
        repeat (8) @(posedge clock);
        st(lccc_pkg::ST_FAST);
        chk("charge_status_out", 0, charge_status_out_oe_n);
        chk("present", 0, supply_present_out_oe_n);
        die_temp_limit <= 1'b1;
        repeat (5) @(posedge clock);
        chk("reduce", 1, current_reduce);
        {die_temp_limit, pack_thermistor_in_bad} <= 2'b01;
        repeat (5) @(posedge clock);
        chk("hold", 0, {charge_enable, fault_out_oe_n});
        pack_thermistor_in_grounded <= 1'b1;
        repeat (5) @(posedge clock);
        chk("ntc ground", 3, {charge_enable, fault_out_oe_n});
        {pack_thermistor_in_bad, pack_thermistor_in_grounded} <= 2'b00;
        repeat (5) @(posedge clock);
        chk("resume", 3, {charge_enable, fault_out_oe_n});
        cell_mv <= 4200;
        repeat (6) @(posedge clock);
        cell_mv <= 3700;
        repeat (6) @(posedge clock);
        chk("tenth", 3, {charge_status_weak_en, charge_status_out_oe_n});
        $display("test charge done");
        power_down_n <= 1'b0;
        repeat (6) @(posedge clock);
        st(lccc_pkg::ST_SHUTDOWN);
        bus(1'b0, lccc_pkg::OFF_TIMER, 0);
        chk("timer", 0, rd);
        chk("weak", 0, {charge_enable, charge_status_weak_en});
        $display("test shutdown done");
        bus(1'b1, lccc_pkg::OFF_CTRL, 1);
        cell_mv <= 2000;
        power_down_n <= 1'b1;
        repeat (8) @(posedge clock);
        st(lccc_pkg::ST_TRICKLE);
        chk("scale", 1, current_scale_tenth);
        repeat (53960) @(posedge clock);
        st(lccc_pkg::ST_TRICKLE);
        repeat (60) @(posedge clock);
        st(lccc_pkg::ST_BADCELL);
        chk("bad", 2, {charge_status_out_oe_n, fault_out_oe_n});
        repeat (20) @(posedge clock);
        st(lccc_pkg::ST_BADCELL);
        cell_mv <= 3000;
        repeat (8) @(posedge clock);
        st(lccc_pkg::ST_FAST);
        $display("test badcell done");
        timer_pin_grounded <= 1'b1;
        repeat (3) @(posedge clock);
        bus(1'b1, lccc_pkg::OFF_CTRL, 0);
        repeat (4) @(posedge clock);
        st(lccc_pkg::ST_FAST);
        timer_pin_grounded <= 1'b0;
        cell_mv <= 4200;
        repeat (6) @(posedge clock);
        st(lccc_pkg::ST_DONE);
        chk("end", 1, {charge_enable, charge_status_out_oe_n});
        bus(1'b1, lccc_pkg::OFF_CTRL, 1);
        cell_mv <= 4000;
        repeat (3) @(posedge clock);
        st(lccc_pkg::ST_DONE);
        repeat (20) @(posedge clock);
        st(lccc_pkg::ST_FAST);
        $display("test recharge done");
        summarize();
    end
endmodule : testbench

//--- core/lccc_charge_ctrl.sv
// Overview of operation
// - Start a cycle only with supply ok, program resistor present, power-down released.
// - Cell under trickle threshold at start: trickle mode, one tenth current.
// - Leave trickle for fast charge once cell rises above trickle threshold.
// - Tenth-current: latch flag, drop strong status pull-down, enable weak sink.
// - Tenth latch clears only on power-down assertion or supply cycling.
// - Timer expiry ends cycle, stops current, floats charge status.
// - Total time scales linearly with timing capacitance, three hours at reference.
// - Timer runs once supply is above lockout and power-down released.
// - Grounded timing pin disables the timer completely.
// - After timeout, restart on cell below recharge threshold, supply cycling or power-down pulse.
// - After normal end, restart when cell falls below recharge threshold.
// - Low cell must persist a few milliseconds before recharge starts.
// - Cell low for quarter time: terminate, float status, latch fault low.
// - Bad-cell fault clears on supply cycling, power-down, or cell above threshold.
// - Recharge comparator ignored after bad-cell termination until fault clears.
// - Hold shutdown until supply above lockout, with hysteresis on lockout.
// - Shutdown when supply near cell; leave only with larger headroom.
// - Power-down asserted turns regulator off and resets the timer.
// - Reduce commanded current while die temperature flag is set.
// - No supply: sleep mode, charging disabled.
// - Thermistor out of range: pause, freeze timer, unlatched fault, status kept.
// - Grounded thermistor input disables the temperature hold.
// - Supply-present pulls low with supply above lockout and headroom.
`timescale 1ns/1ps
module lccc_charge_ctrl #(
    parameter int TICK_CYCLES = lccc_pkg::TICK_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        supply_rise_ok,
    input  wire logic        supply_fall_ok,
    input  wire logic        headroom_70_ok,
    input  wire logic        headroom_35_ok,
    input  wire logic        current_set_pin_ok,
    input  wire logic        power_down_n,
    input  wire logic        cell_terminal_above_trickle,
    input  wire logic        cell_terminal_below_recharge,
    input  wire logic        charge_current_tenth,
    input  wire logic        die_temp_limit,
    input  wire logic        pack_thermistor_in_bad,
    input  wire logic        pack_thermistor_in_grounded,
    input  wire logic        timer_pin_grounded,
    output logic             charge_enable,
    output logic             current_scale_tenth,
    output logic             current_reduce,
    output logic             charge_status_out_o,
    output logic             charge_status_out_oe_n,
    output logic             charge_status_weak_en,
    output logic             fault_out_o,
    output logic             fault_out_oe_n,
    output logic             supply_present_out_o,
    output logic             supply_present_out_oe_n
);

    typedef struct packed {
        lccc_pkg::lccc_state_t              state;
        logic                               lockout_ok;
        logic                               headroom_ok;
        logic                               tenth_latch;
        logic [lccc_pkg::DIV_W-1:0]         div_cnt;
        logic                               tick;
        logic [lccc_pkg::TIMER_W-1:0]       timer_cnt;
        logic [lccc_pkg::FILT_W-1:0]        filt_cnt;
        logic [lccc_pkg::CAP_W-1:0]         cap_code;
        logic                               wr_pend;
        logic [11:0]                        wr_addr;
        logic [31:0]                        rdata;
        logic                               chg_en;
        logic                               tenth_cmd;
        logic                               reduce;
        logic                               strong_oe_n;
        logic                               weak_en;
        logic                               fault_oe_n;
        logic                               present_oe_n;
    } lccc_regs_t;

    lccc_regs_t r_reg;
    lccc_regs_t r_next;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [lccc_pkg::IN_COUNT-1:0] raw_in;
    logic [lccc_pkg::IN_COUNT-1:0] s_in;

    assign raw_in = {timer_pin_grounded, pack_thermistor_in_grounded,
                     pack_thermistor_in_bad, die_temp_limit,
                     charge_current_tenth, cell_terminal_below_recharge,
                     cell_terminal_above_trickle, power_down_n,
                     current_set_pin_ok, headroom_35_ok, headroom_70_ok,
                     supply_fall_ok, supply_rise_ok};

    genvar gi;
    generate
        for (gi = 0; gi < lccc_pkg::IN_COUNT; gi++) begin : g_sync
            lccc_sync u_sync (
                .clock    (clock),
                .resetn   (resetn),
                .async_in (raw_in[gi]),
                .sync_out (s_in[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Decoded conditions

    logic                         supply_ok;
    logic                         pd_ok;
    logic                         start_ok;
    logic                         hold;
    logic                         timer_dis;
    logic                         charging;
    logic [lccc_pkg::TIMER_W-1:0] limit;
    logic [lccc_pkg::TIMER_W-1:0] quarter;
    logic                         bus_take;

    assign limit = lccc_pkg::TIMER_W'(r_reg.cap_code
                   * lccc_pkg::TICKS_PER_NF);
    assign quarter   = limit >> 2;
    assign supply_ok = r_reg.lockout_ok && r_reg.headroom_ok;
    assign pd_ok     = s_in[lccc_pkg::IN_PD_N];
    assign start_ok  = supply_ok && pd_ok && s_in[lccc_pkg::IN_CURRENT_SET_PIN_OK];
    assign hold      = s_in[lccc_pkg::IN_NTC_BAD]
                       && !s_in[lccc_pkg::IN_NTC_GND];
    assign timer_dis = s_in[lccc_pkg::IN_TMR_GND];
    assign charging  = (r_reg.state == lccc_pkg::ST_TRICKLE)
                       || (r_reg.state == lccc_pkg::ST_FAST);
    assign bus_take  = hsel && hready && htrans[1];

    function automatic logic [31:0] read_mux(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            lccc_pkg::OFF_CTRL:   v[lccc_pkg::CAP_W-1:0] = r_reg.cap_code;
            lccc_pkg::OFF_STATUS: begin
                v[lccc_pkg::ST_STATE_LSB +: 3] = r_reg.state;
                v[lccc_pkg::ST_TENTH_BIT]      = r_reg.tenth_latch;
                v[lccc_pkg::ST_HOLD_BIT]       = hold;
                v[lccc_pkg::ST_LOCK_BIT]       = r_reg.lockout_ok;
                v[lccc_pkg::ST_HEAD_BIT]       = r_reg.headroom_ok;
                v[lccc_pkg::ST_FAULT_BIT]      =
                    (r_reg.state == lccc_pkg::ST_BADCELL);
            end
            lccc_pkg::OFF_TIMER:  v[lccc_pkg::TIMER_W-1:0] = r_reg.timer_cnt;
            default:              v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_mux

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        r_next = r_reg;

        // Timebase divider
        r_next.tick = 1'b0;
        if (r_reg.div_cnt == lccc_pkg::DIV_W'(TICK_CYCLES - 1)) begin
            r_next.div_cnt = '0;
            r_next.tick    = 1'b1;
        end else begin
            r_next.div_cnt = r_reg.div_cnt + 1'b1;
        end

        if (s_in[lccc_pkg::IN_SUP_RISE]) begin
            r_next.lockout_ok = 1'b1;
        end else if (!s_in[lccc_pkg::IN_SUP_FALL]) begin
            r_next.lockout_ok = 1'b0;
        end
        if (s_in[lccc_pkg::IN_HEAD_70]) begin
            r_next.headroom_ok = 1'b1;
        end else if (!s_in[lccc_pkg::IN_HEAD_35]) begin
            r_next.headroom_ok = 1'b0;
        end

        // Bus: write lands in the data phase
        if (r_reg.wr_pend && r_reg.wr_addr == lccc_pkg::OFF_CTRL) begin
            r_next.cap_code = hwdata[lccc_pkg::CAP_W-1:0];
        end
        r_next.wr_pend = 1'b0;
        if (bus_take) begin
            r_next.wr_pend = hwrite;
            r_next.wr_addr = haddr[11:0];
            r_next.rdata   = hwrite ? 32'h0000_0000 : read_mux(haddr[11:0]);
        end

        if (!supply_ok) begin
            r_next.state       = lccc_pkg::ST_SLEEP;
            r_next.timer_cnt   = '0;
            r_next.tenth_latch = 1'b0;
        end else if (!pd_ok) begin
            r_next.state       = lccc_pkg::ST_SHUTDOWN;
            r_next.timer_cnt   = '0;
            r_next.tenth_latch = 1'b0;
        end else begin
            unique case (r_reg.state)
                lccc_pkg::ST_SLEEP, lccc_pkg::ST_SHUTDOWN: begin
                    if (start_ok) begin
                        r_next.timer_cnt = '0;
                        r_next.filt_cnt  = '0;
                        r_next.state = s_in[lccc_pkg::IN_CELL_TRK]
                                       ? lccc_pkg::ST_FAST
                                       : lccc_pkg::ST_TRICKLE;
                    end
                end
                lccc_pkg::ST_TRICKLE, lccc_pkg::ST_FAST: begin
                    if (r_reg.tick && !hold && !timer_dis) begin
                        r_next.timer_cnt = r_reg.timer_cnt + 1'b1;
                    end
                    if (r_reg.state == lccc_pkg::ST_FAST
                        && s_in[lccc_pkg::IN_TENTH]) begin
                        r_next.tenth_latch = 1'b1;
                    end
                    if (r_reg.state == lccc_pkg::ST_TRICKLE) begin
                        if (s_in[lccc_pkg::IN_CELL_TRK]) begin
                            r_next.state = lccc_pkg::ST_FAST;
                        end else if (!timer_dis
                                     && r_reg.timer_cnt >= quarter) begin
                            r_next.state = lccc_pkg::ST_BADCELL;
                        end
                    end else if (!timer_dis
                                 && r_reg.timer_cnt >= limit) begin
                        r_next.state = lccc_pkg::ST_DONE;
                    end
                end
                lccc_pkg::ST_DONE: begin
                    // Only the recharge path restarts here
                    if (!s_in[lccc_pkg::IN_CELL_RCH]) begin
                        r_next.filt_cnt = '0;
                    end else if (r_reg.tick) begin
                        r_next.filt_cnt = r_reg.filt_cnt + 1'b1;
                    end
                    if (r_reg.filt_cnt >= lccc_pkg::RECHARGE_FILTER_TICKS
                        && start_ok) begin
                        r_next.state     = lccc_pkg::ST_FAST;
                        r_next.timer_cnt = '0;
                        r_next.filt_cnt  = '0;
                    end
                end
                lccc_pkg::ST_BADCELL: begin
                    if (s_in[lccc_pkg::IN_CELL_TRK] && start_ok) begin
                        r_next.state     = lccc_pkg::ST_FAST;
                        r_next.timer_cnt = '0;
                    end
                end
                default: begin
                    r_next.state = lccc_pkg::ST_SLEEP;
                end
            endcase
        end

        // Registered pin commands follow the next state
        r_next.chg_en    = (r_next.state == lccc_pkg::ST_TRICKLE
                           || r_next.state == lccc_pkg::ST_FAST) && !hold;
        r_next.tenth_cmd = (r_next.state == lccc_pkg::ST_TRICKLE);
        r_next.reduce    = r_next.chg_en && s_in[lccc_pkg::IN_DIE_HOT];
        r_next.strong_oe_n = !((r_next.state == lccc_pkg::ST_TRICKLE
                              || r_next.state == lccc_pkg::ST_FAST)
                              && !r_next.tenth_latch);
        r_next.weak_en     = (r_next.state == lccc_pkg::ST_TRICKLE
                              || r_next.state == lccc_pkg::ST_FAST)
                              && r_next.tenth_latch;
        r_next.fault_oe_n  = !((r_next.state == lccc_pkg::ST_BADCELL)
                              || (hold
                                  && r_next.state != lccc_pkg::ST_SLEEP
                                  && r_next.state != lccc_pkg::ST_SHUTDOWN));
        r_next.present_oe_n = !(r_next.lockout_ok && r_next.headroom_ok);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r_reg              <= '0;
            r_reg.state        <= lccc_pkg::ST_SLEEP;
            r_reg.cap_code     <= lccc_pkg::CAP_RESET;
            r_reg.strong_oe_n  <= 1'b1;
            r_reg.fault_oe_n   <= 1'b1;
            r_reg.present_oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Zero wait states keep the slave simple; no error cases exist
    assign hreadyout               = 1'b1;
    assign hresp                   = 1'b0;
    assign hrdata                  = r_reg.rdata;
    assign charge_enable           = r_reg.chg_en;
    assign current_scale_tenth     = r_reg.tenth_cmd;
    assign current_reduce          = r_reg.reduce;
    assign charge_status_out_o     = 1'b0;
    assign charge_status_out_oe_n  = r_reg.strong_oe_n;
    assign charge_status_weak_en   = r_reg.weak_en;
    assign fault_out_o             = 1'b0;
    assign fault_out_oe_n          = r_reg.fault_oe_n;
    assign supply_present_out_o    = 1'b0;
    assign supply_present_out_oe_n = r_reg.present_oe_n;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_idle_start;
        (r_reg.state == lccc_pkg::ST_SLEEP
         || r_reg.state == lccc_pkg::ST_SHUTDOWN) && start_ok;
    endsequence

    sequence s_trickle_rise;
        r_reg.state == lccc_pkg::ST_TRICKLE && supply_ok && pd_ok
        && s_in[lccc_pkg::IN_CELL_TRK];
    endsequence

    a_start_trickle: assert property (
        s_idle_start ##0 !s_in[lccc_pkg::IN_CELL_TRK]
        |=> r_reg.state == lccc_pkg::ST_TRICKLE && r_reg.tenth_cmd)
        else $error("low cell start did not enter trickle");

    a_trickle_exit: assert property (
        s_trickle_rise |=> r_reg.state == lccc_pkg::ST_FAST)
        else $error("trickle did not leave on cell rise");

    a_tenth_status: assert property (
        charging && r_reg.tenth_latch
        |-> r_reg.strong_oe_n && r_reg.weak_en)
        else $error("tenth latch not shown on status pin");

    a_tenth_sticky: assert property (
        r_reg.tenth_latch && supply_ok && pd_ok |=> r_reg.tenth_latch)
        else $error("tenth latch lost without clear");

    a_timeout_end: assert property (
        r_reg.state == lccc_pkg::ST_FAST && supply_ok && pd_ok
        && !timer_dis && r_reg.timer_cnt >= limit
        |=> r_reg.state == lccc_pkg::ST_DONE && !r_reg.chg_en
            ##0 r_reg.strong_oe_n && !r_reg.weak_en)
        else $error("timeout did not end the cycle");

    a_timer_disable: assert property (
        timer_dis && charging && supply_ok && pd_ok
        && !s_in[lccc_pkg::IN_CELL_TRK]
        |=> $stable(r_reg.timer_cnt) && charging)
        else $error("timer moved while disabled");

    a_badcell_lock: assert property (
        r_reg.state == lccc_pkg::ST_BADCELL && supply_ok && pd_ok
        && !s_in[lccc_pkg::IN_CELL_TRK]
        |=> r_reg.state == lccc_pkg::ST_BADCELL && !r_reg.fault_oe_n)
        else $error("bad cell state left without clear");

    a_recharge_filter: assert property (
        r_reg.state == lccc_pkg::ST_DONE
        && r_reg.filt_cnt < lccc_pkg::RECHARGE_FILTER_TICKS
        |=> r_reg.state != lccc_pkg::ST_FAST)
        else $error("recharge started before filter time");

    a_shutdown_reset: assert property (
        supply_ok && !pd_ok |=> r_reg.timer_cnt == '0 && !r_reg.chg_en)
        else $error("shutdown did not reset timer");

    a_lockout_hold: assert property (
        !r_reg.lockout_ok && !s_in[lccc_pkg::IN_SUP_RISE]
        |=> !r_reg.lockout_ok ##0 r_reg.state == lccc_pkg::ST_SLEEP)
        else $error("lockout released without rising level");

    a_thermal_cut: assert property (
        r_reg.reduce |-> r_reg.chg_en)
        else $error("current reduce without charging");

    a_hold_pause: assert property (
        hold && charging && supply_ok && pd_ok
        |=> !r_reg.chg_en && !r_reg.fault_oe_n)
        else $error("thermistor hold did not pause charging");

endmodule : lccc_charge_ctrl

//--- core/lccc_pkg.sv
package lccc_pkg;

    // Charge cycle states
    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_SHUTDOWN,
        ST_TRICKLE,
        ST_FAST,
        ST_DONE,
        ST_BADCELL
    } lccc_state_t;

    // Clock and timebase
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int DIV_W         = 18;

    // Timer scaling: reference capacitor gives reference time
    localparam int REF_TIME_H    = 3;
    localparam int REF_CAP_NF    = 100;
    localparam int TICK_MS       = TICK_NS / 1000000;
    localparam int TICKS_PER_NF  =
        (REF_TIME_H * 3600 * 1000) / (TICK_MS * REF_CAP_NF);
    localparam int TIMER_W       = 28;
    localparam int CAP_W         = 10;
    localparam logic [CAP_W-1:0] CAP_RESET = 10'h064;

    // Recharge filter length in ticks
    localparam int RECHARGE_FILTER_MS    = 4;
    localparam int FILT_W                = 3;
    localparam logic [FILT_W-1:0] RECHARGE_FILTER_TICKS =
        3'h4;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_TIMER  = 12'h008;

    // Status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_TENTH_BIT = 3;
    localparam int ST_HOLD_BIT  = 4;
    localparam int ST_LOCK_BIT  = 5;
    localparam int ST_HEAD_BIT  = 6;
    localparam int ST_FAULT_BIT = 7;

    // Synchronised input indices
    localparam int IN_SUP_RISE = 0;
    localparam int IN_SUP_FALL = 1;
    localparam int IN_HEAD_70  = 2;
    localparam int IN_HEAD_35  = 3;
    localparam int IN_CURRENT_SET_PIN_OK  = 4;
    localparam int IN_PD_N     = 5;
    localparam int IN_CELL_TRK = 6;
    localparam int IN_CELL_RCH = 7;
    localparam int IN_TENTH    = 8;
    localparam int IN_DIE_HOT  = 9;
    localparam int IN_NTC_BAD  = 10;
    localparam int IN_NTC_GND  = 11;
    localparam int IN_TMR_GND  = 12;
    localparam int IN_COUNT    = 13;

endpackage : lccc_pkg

//--- core/lccc_sync.sv
`timescale 1ns/1ps
module lccc_sync (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic async_in,
    output logic      sync_out
);

    typedef struct packed {
        logic meta;
        logic stable;
    } lccc_sync_t;

    lccc_sync_t s_reg;
    lccc_sync_t s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.meta   = async_in;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stable;

endmodule : lccc_sync
